// file: hdl/rpa_prom_access.sv
// Top of the registered PROM program access block: array, extra cells,
// output register and output enable logic.
// Assumes all pins are synchronous to clk; shared pins come in as levels plus
// supervoltage flags; rst models the fresh, unprogrammed part at power-up.
`timescale 1ns/1ps
`default_nettype none
module rpa_prom_access #(
   parameter int PP_MIN_CYC = rpa_pkg::PP_MIN_CYC     // Least program pulse in cycles
) (
   input  wire logic        clk,                       // 125 MHz clock
   input  wire logic        rst,                       // Sync reset, active high
   input  wire logic [10:0] addr,                      // Address pins
   input  wire logic [7:0]  data_in,                   // Data pins, input side
   input  wire logic        register_clock,            // Clock pin, also program strobe
   input  wire logic        enable_n,                  // Enable pin, also verify strobe
   input  wire logic        init_n,                    // Initialize pin logic level
   input  wire logic        programming_supervoltage,  // Initialize pin at supervoltage
   input  wire logic        a1_supervoltage,           // Address bit 1 at supervoltage
   input  wire logic        clock_supervoltage,        // Clock pin at supervoltage
   output logic [7:0]       data_out,                  // Data pins, output side
   output logic             data_oe,                   // Data pins driven when high
   output logic             sync_enable_on             // Sync enable cell programmed
);
   localparam rpa_pkg::rpa_cnt_t PP_LAST = rpa_pkg::rpa_cnt_t'(PP_MIN_CYC - 1);
   localparam rpa_pkg::rpa_cnt_t PP_DONE = rpa_pkg::rpa_cnt_t'(PP_MIN_CYC);
   localparam rpa_pkg::rpa_cnt_t CNT_ONE = 24'h000001;

   // Nonvolatile contents and control state
   logic [7:0]                   mem_q [0:rpa_pkg::ARRAY_WORDS-1];
   logic [rpa_pkg::ARRAY_WORDS-1:0] prog_flag_ff;
   logic [7:0]                   init_byte_ff;
   logic                         init_prog_ff;
   logic                         sync_ff;
   logic                         clk_prev_ff;
   rpa_pkg::rpa_cnt_t            cnt_ff;
   logic [7:0]                   out_ff;
   logic                         oe_ff;
   logic [7:0]                   nxt_out;
   logic                         nxt_oe;
   rpa_pkg::rpa_sel_t            sel;

   // Shared pins under their programming names
   wire logic program_strobe_n = register_clock;
   wire logic verify_strobe_n  = enable_n;

   rpa_mode_dec u_dec (
      .programming_supervoltage (programming_supervoltage),
      .clock_supervoltage       (clock_supervoltage),
      .a1_supervoltage          (a1_supervoltage),
      .program_strobe_n         (program_strobe_n),
      .verify_strobe_n          (verify_strobe_n),
      .addr_bit2                (addr[rpa_pkg::ADDR_SEL_BIT]),
      .sel                      (sel)
   );

   // Decode of the current mode and the addressed word
   wire logic       is_read   = sel.mode == rpa_pkg::RPA_READ;
   wire logic       is_vfy    = sel.mode == rpa_pkg::RPA_VERIFY;
   wire logic       is_prog   = sel.mode == rpa_pkg::RPA_PROGRAM;
   wire logic       is_blank1 = sel.mode == rpa_pkg::RPA_BLANK1;
   wire logic       is_blank0 = sel.mode == rpa_pkg::RPA_BLANK0;
   wire logic       clk_rise  = register_clock && !clk_prev_ff;
   wire logic       word_prog = prog_flag_ff[addr];
   wire logic [7:0] rd_word   = word_prog ? mem_q[addr] : rpa_pkg::UNPROG_READ;
   wire logic       vfy_array = is_vfy && sel.tgt == rpa_pkg::RPA_T_ARRAY;

   // A pulse takes effect once it has lasted the least pulse width; longer
   // pulses commit only once, so overprogram pulses simply reinforce
   wire logic commit     = is_prog && cnt_ff == PP_LAST;
   wire logic cmt_array  = commit && sel.tgt == rpa_pkg::RPA_T_ARRAY;
   wire logic cmt_initb  = commit && sel.tgt == rpa_pkg::RPA_T_INITB;
   wire logic cmt_sync   = commit && sel.tgt == rpa_pkg::RPA_T_SYNC;
   wire rpa_pkg::rpa_cnt_t nxt_cnt = !is_prog        ? '0 :
                                     cnt_ff == PP_DONE ? cnt_ff : cnt_ff + CNT_ONE;

   // Output enable: async follows the pin, sync only moves on a clock edge
   wire logic read_oe = sync_ff ? (clk_rise ? !enable_n : oe_ff)
                                : !enable_n;

   // Next output register value per mode
   always_comb begin
      nxt_out = out_ff;
      nxt_oe  = 1'b0;
      unique case (1'b1)
         is_read: begin
            if (!init_n) begin
               nxt_out = init_byte_ff;
            end else if (clk_rise) begin
               nxt_out = rd_word;
            end
            nxt_oe = read_oe;
         end
         vfy_array: begin
            nxt_out = rd_word;
            nxt_oe  = 1'b1;
         end
         is_blank1: begin
            nxt_out = word_prog ? mem_q[addr] : rpa_pkg::BLANK_ONES;
            nxt_oe  = 1'b1;
         end
         is_blank0: begin
            nxt_out = word_prog ? mem_q[addr] : rpa_pkg::BLANK_ZEROS;
            nxt_oe  = 1'b1;
         end
         default: begin
            nxt_oe  = 1'b0;
         end
      endcase
   end

   // Array cells hold no reset; the programmed flags mask unwritten words
   always_ff @(posedge clk) begin
      if (cmt_array) begin
         mem_q[addr] <= data_in;
      end
   end

   // Programmed flags and extra cells
   always_ff @(posedge clk) begin
      if (rst) begin
         prog_flag_ff <= '0;
         init_byte_ff <= rpa_pkg::INIT_BYTE_RST;
         init_prog_ff <= 1'b0;
         sync_ff      <= 1'b0;
      end else begin
         if (cmt_array) begin
            prog_flag_ff[addr] <= 1'b1;
         end
         if (cmt_initb) begin
            init_byte_ff <= data_in;
            init_prog_ff <= 1'b1;
         end
         if (cmt_sync) begin
            sync_ff <= 1'b1;
         end
      end
   end

   // Pulse counter, clock edge detect and output register
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_ff      <= '0;
         clk_prev_ff <= 1'b1;
         out_ff      <= rpa_pkg::INIT_BYTE_RST;
         oe_ff       <= 1'b0;
      end else begin
         cnt_ff      <= nxt_cnt;
         clk_prev_ff <= register_clock;
         out_ff      <= nxt_out;
         oe_ff       <= nxt_oe;
      end
   end

   assign data_out       = out_ff;
   assign data_oe        = oe_ff;
   assign sync_enable_on = sync_ff;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   chk_read_capture: assert property (
      is_read && init_n && clk_rise |=> out_ff == $past(rd_word))
      else $error("read edge did not load addressed word");

   chk_init_load: assert property (
      is_read && !init_n |=> out_ff == $past(init_byte_ff))
      else $error("initialize did not load the initialize byte");

   chk_init_default: assert property (
      !init_prog_ff |-> init_byte_ff == rpa_pkg::INIT_BYTE_RST)
      else $error("initialize byte not zero before programming");

   chk_init_program: assert property (
      cmt_initb |=> init_byte_ff == $past(data_in) && init_prog_ff)
      else $error("initialize byte program failed");

   chk_async_enable: assert property (
      is_read && !sync_ff |=> oe_ff == !$past(enable_n))
      else $error("async enable did not follow pin");

   chk_sync_hold: assert property (
      is_read && sync_ff && !clk_rise && $past(is_read) |=> oe_ff == $past(oe_ff))
      else $error("sync enable moved without clock edge");

   chk_sync_edge: assert property (
      is_read && sync_ff && clk_rise |=> oe_ff == !$past(enable_n))
      else $error("sync enable missed clock edge");

   chk_inhibit_hiz: assert property (
      sel.mode == rpa_pkg::RPA_INHIBIT [*2] |-> !oe_ff)
      else $error("outputs driven in program inhibit");

   chk_blank_ones: assert property (
      is_blank1 && !word_prog |=> oe_ff && out_ff == rpa_pkg::BLANK_ONES)
      else $error("blank ones check not all ones");

   chk_blank_zeros: assert property (
      is_blank0 && !word_prog |=> oe_ff && out_ff == rpa_pkg::BLANK_ZEROS)
      else $error("blank zeros check not all zeros");

   chk_sync_program: assert property (
      cmt_sync |=> sync_ff)
      else $error("sync enable cell not set");

   chk_verify_drive: assert property (
      vfy_array |=> oe_ff && out_ff == $past(rd_word))
      else $error("verify did not drive the addressed word");

   chk_blank_stored: assert property (
      is_blank1 && word_prog |=> oe_ff && out_ff == $past(rd_word))
      else $error("blank check hid a programmed word");

   chk_program_hiz: assert property (
      is_prog |=> !oe_ff)
      else $error("outputs driven during a program pulse");

   cov_array_commit: cover property (cmt_array ##1 vfy_array);
   cov_init_load:    cover property (cmt_initb ##[1:20] (is_read && !init_n));
   cov_sync_edge:    cover property (sync_ff && is_read && clk_rise && !enable_n);
   cov_blank:        cover property (is_blank1 ##[1:20] is_blank0);
   cov_sync_off:     cover property (sync_ff && is_read && clk_rise && enable_n);
endmodule : rpa_prom_access
`default_nettype wire

// file: hdl/rpa_pkg.sv
// Constants, types and mode encodings for the registered PROM program access block.
// Assumes a 125 MHz clock and pins already resolved to logic levels plus
// separate flags that tell where a supervoltage is present.
// Summary of operation
// - In read mode a rising register clock loads the addressed word into the output register.
// - From read mode, supervoltage on the initialize pin gives program inhibit, outputs off.
// - An extra initialize byte beyond the 2048 words feeds the initialize load.
// - The initialize byte reads as all zeros until it is programmed.
// - Supervoltage on address bit 1 with bit 2 low selects the initialize byte.
// - Outputs start in asynchronous enable; sync enable only after its cell is programmed.
// - In sync mode outputs stay off after enable falls until the next clock edge.
// - In sync mode outputs stay driven after enable rises until the next clock edge.
// - Unprogrammed means all ones in blank-ones mode and all zeros in blank-zeros mode.
// - A low initialize input loads the initialize byte at once, overriding the clock.
package rpa_pkg;
   localparam int          ADDR_W        = 11;
   localparam int          DATA_W        = 8;
   localparam int          ARRAY_WORDS   = 2048;
   localparam int          ADDR_SEL_BIT  = 2;       // Address bit that picks the extra cell
   localparam logic [7:0]  INIT_BYTE_RST = 8'h00;   // Shipped initialize byte
   localparam logic [7:0]  BLANK_ONES    = 8'hff;
   localparam logic [7:0]  BLANK_ZEROS   = 8'h00;
   localparam logic [7:0]  UNPROG_READ   = 8'h00;   // Erased cell read value in normal modes
   // Program pulse timing
   localparam int          CLK_MHZ       = 125;
   localparam int          T_PP_MIN_US   = 100;
   localparam int          PP_MIN_CYC    = T_PP_MIN_US * CLK_MHZ;
   localparam int          CNT_W         = 24;

   typedef logic [CNT_W-1:0] rpa_cnt_t;

   typedef enum logic [2:0] {
      RPA_READ    = 3'h0,
      RPA_INHIBIT = 3'h1,
      RPA_PROGRAM = 3'h3,
      RPA_VERIFY  = 3'h2,
      RPA_BLANK1  = 3'h6,
      RPA_BLANK0  = 3'h7
   } rpa_mode_t;

   typedef enum logic [1:0] {
      RPA_T_ARRAY = 2'h0,
      RPA_T_INITB = 2'h1,
      RPA_T_SYNC  = 2'h3
   } rpa_target_t;

   typedef struct packed {
      rpa_mode_t   mode;
      rpa_target_t tgt;
   } rpa_sel_t;
endpackage : rpa_pkg

// file: hdl/rpa_mode_dec.sv
// Mode decoder for the registered PROM program access block.
// Assumes supervoltage presence arrives as separate flags, synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module rpa_mode_dec (
   input  wire logic           programming_supervoltage, // Initialize pin at supervoltage
   input  wire logic           clock_supervoltage,       // Clock pin at supervoltage
   input  wire logic           a1_supervoltage,          // Address bit 1 at supervoltage
   input  wire logic           program_strobe_n,         // Program strobe, low active
   input  wire logic           verify_strobe_n,          // Verify strobe, low active
   input  wire logic           addr_bit2,                // Address bit 2 level
   output var  rpa_pkg::rpa_sel_t sel                    // Decoded mode and target
);
   // Strobe pair decode under supervoltage
   wire logic prog_pair = !program_strobe_n && verify_strobe_n;
   wire logic vfy_pair  = program_strobe_n && !verify_strobe_n;
   wire logic blank_sel = clock_supervoltage && !programming_supervoltage;

   // Both strobes low is not a legal pair; it is treated as inhibit to protect cells
   wire rpa_pkg::rpa_mode_t hv_mode = prog_pair ? rpa_pkg::RPA_PROGRAM :
                                      vfy_pair  ? rpa_pkg::RPA_VERIFY  :
                                                  rpa_pkg::RPA_INHIBIT;

   // Supervoltage flags pick the mode and the extra addressed cells
   assign sel.mode = blank_sel ? (verify_strobe_n ? rpa_pkg::RPA_BLANK0
                                                  : rpa_pkg::RPA_BLANK1) :
                     programming_supervoltage ? hv_mode : rpa_pkg::RPA_READ;
   assign sel.tgt  = !a1_supervoltage ? rpa_pkg::RPA_T_ARRAY :
                     addr_bit2        ? rpa_pkg::RPA_T_SYNC  :
                                        rpa_pkg::RPA_T_INITB;
endmodule : rpa_mode_dec
`default_nettype wire

// file: verif/rpa_programmer.sv
// Behavioural model of the external programmer that drives the PROM pins.
// Assumes the bench calls its tasks one at a time; pins change 1 ns after clk rises.
`timescale 1ns/1ps
`default_nettype none
module rpa_programmer (
   input  wire logic        clk,                      // Bench clock
   input  wire logic [7:0]  data_out,                 // Device data pins, output side
   output logic      [10:0] addr,                     // Address pins
   output logic      [7:0]  data_in,                  // Data pins, input side
   output logic             register_clock,           // Clock pin, program strobe
   output logic             enable_n,                 // Enable pin, verify strobe
   output logic             init_n,                   // Initialize pin level
   output logic             programming_supervoltage, // Supervoltage on initialize pin
   output logic             a1_supervoltage,          // Supervoltage on address bit 1
   output logic             clock_supervoltage        // Supervoltage on clock pin
);
   // Start in read mode, clock, enable and initialize high
   initial begin
      {addr, data_in} = '0;
      {register_clock, enable_n, init_n} = 3'h7;
      {programming_supervoltage, a1_supervoltage, clock_supervoltage} = 3'h0;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   // Released data pins show the inverse, never a stale value
   task automatic enter_prog(input logic on);
      {register_clock, enable_n, init_n} = 3'h7;
      step(1);
      programming_supervoltage = on;
      if (!on) data_in = ~data_in;
      step(3);
   endtask : enter_prog
   task automatic pulse(input int cyc);
      register_clock = 1'b0;
      step(cyc);
      register_clock = 1'b1;
      step(1);
   endtask : pulse
   task automatic verify(output logic [7:0] v);
      enable_n = 1'b0;
      step(3);
      v = data_out;
      enable_n = 1'b1;
      step(1);
   endtask : verify
   // Short pulses with a verify after each, then the overprogram pulse
   task automatic prog_byte(input logic [10:0] a, input logic [7:0] d, input int p,
                            output logic ok);
      int         x;
      logic [7:0] v;
      addr = a;
      data_in = d;
      ok = 1'b0;
      x = 0;
      while (!ok && x < 4) begin
         pulse(p);
         x++;
         verify(v);
         ok = (v === d);
      end
      if (ok) pulse(24 * x * p);
   endtask : prog_byte
   // Single-pulse method: one long pulse, one verify, no retry
   task automatic prog_single(input logic [10:0] a, input logic [7:0] d, input int cyc,
                              output logic ok);
      logic [7:0] v;
      addr = a;
      data_in = d;
      pulse(cyc);
      verify(v);
      ok = (v === d);
   endtask : prog_single
   // Enable pin moved with the register clock standing still
   task automatic set_enable(input logic en_n, input int n);
      enable_n = en_n;
      step(n);
   endtask : set_enable
   // One rising register clock edge in read mode
   task automatic clock_edge();
      register_clock = 1'b0;
      step(1);
      register_clock = 1'b1;
      step(3);
   endtask : clock_edge
   // Extra cells: bit 2 low picks the initial byte, high the enable option
   task automatic prog_extra(input logic bit2, input logic [7:0] d, input int cyc);
      a1_supervoltage = 1'b1;
      addr = {8'h00, bit2, 2'h0};
      data_in = d;
      pulse(cyc);
      a1_supervoltage = 1'b0;
      step(1);
   endtask : prog_extra
   task automatic blank(input logic ones, input logic [10:0] a, output logic [7:0] v);
      clock_supervoltage = 1'b1;
      enable_n = !ones;
      addr = a;
      step(3);
      v = data_out;
      clock_supervoltage = 1'b0;
      enable_n = 1'b1;
      step(1);
   endtask : blank
   task automatic read(input logic [10:0] a, output logic [7:0] v);
      register_clock = 1'b0;
      addr = a;
      enable_n = 1'b0;
      step(1);
      register_clock = 1'b1;
      step(3);
      v = data_out;
   endtask : read
   task automatic init_load(output logic [7:0] v);
      init_n = 1'b0;
      step(2);
      v = data_out;
      init_n = 1'b1;
      step(1);
   endtask : init_load
endmodule : rpa_programmer
`default_nettype wire

// file: verif/registered_prom_program_access_tb.sv
// Self-checking bench for the registered PROM program access block.
// Assumes the programmer model drives every pin; pulse unit shortened to P cycles.
`timescale 1ns/1ps
`default_nettype none
module registered_prom_program_access_tb;
   localparam int P = 4;
   logic             clk;
   logic             rst;
   wire logic [10:0] addr;
   wire logic [7:0]  data_in;
   wire logic        register_clock;
   wire logic        enable_n;
   wire logic        init_n;
   wire logic        programming_supervoltage;
   wire logic        a1_supervoltage;
   wire logic        clock_supervoltage;
   wire logic [7:0]  data_out;
   wire logic        data_oe;
   wire logic        sync_enable_on;
   logic [7:0]       v;
   logic             ok;
   int               err_total = 0;
   int               n_tests = 0;
   rpa_prom_access #(.PP_MIN_CYC(P)) DUT (.clk(clk), .rst(rst), .addr(addr),
      .data_in(data_in), .register_clock(register_clock), .enable_n(enable_n),
      .init_n(init_n), .programming_supervoltage(programming_supervoltage),
      .a1_supervoltage(a1_supervoltage), .clock_supervoltage(clock_supervoltage),
      .data_out(data_out), .data_oe(data_oe), .sync_enable_on(sync_enable_on));
   rpa_programmer prog (.clk(clk), .data_out(data_out), .addr(addr), .data_in(data_in),
      .register_clock(register_clock), .enable_n(enable_n), .init_n(init_n),
      .programming_supervoltage(programming_supervoltage),
      .a1_supervoltage(a1_supervoltage), .clock_supervoltage(clock_supervoltage));
   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_total++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk8
   task automatic chk1(input logic got, input logic exp);
      chk8({7'h00, got}, {7'h00, exp});
   endtask : chk1
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : final_report
   // Program, blank check, refused short pulses and read back
   task automatic t_array();
      prog.enter_prog(1'b1);
      chk1(data_oe, 1'b0);
      prog.prog_byte(11'h005, 8'ha5, P, ok);
      chk1(ok, 1'b1);
      prog.prog_byte(11'h006, 8'h3c, P - 1, ok);
      chk1(ok, 1'b0);
      prog.prog_single(11'h7fe, 8'h0f, 100 * P, ok);
      chk1(ok, 1'b1);
      prog.prog_single(11'h7fd, 8'hf0, P - 1, ok);
      chk1(ok, 1'b0);
      prog.enter_prog(1'b0);
      prog.blank(1'b1, 11'h7ff, v);
      chk8(v, 8'hff);
      prog.blank(1'b0, 11'h000, v);
      chk8(v, 8'h00);
      prog.blank(1'b1, 11'h005, v);
      chk8(v, 8'ha5);
      prog.read(11'h005, v);
      chk8(v, 8'ha5);
      chk1(data_oe, 1'b1);
      prog.read(11'h006, v);
      chk8(v, 8'h00);
      prog.read(11'h7fe, v);
      chk8(v, 8'h0f);
      prog.set_enable(1'b1, 3);
      chk1(data_oe, 1'b0);
   endtask : t_array
   // Initial byte ships as zero, then loads its programmed value
   task automatic t_init();
      prog.init_load(v);
      chk8(v, 8'h00);
      prog.enter_prog(1'b1);
      prog.prog_extra(1'b0, 8'h3c, P);
      prog.enter_prog(1'b0);
      prog.init_load(v);
      chk8(v, 8'h3c);
   endtask : t_init
   // Enable option cell, then enable follows clock edges only
   task automatic t_sync();
      chk1(sync_enable_on, 1'b0);
      prog.enter_prog(1'b1);
      prog.prog_extra(1'b1, 8'h00, 100 * P);
      prog.enter_prog(1'b0);
      chk1(sync_enable_on, 1'b1);
      prog.set_enable(1'b0, 3);
      chk1(data_oe, 1'b0);
      prog.read(11'h005, v);
      chk1(data_oe, 1'b1);
      chk8(v, 8'ha5);
      prog.set_enable(1'b1, 3);
      chk1(data_oe, 1'b1);
      prog.clock_edge();
      chk1(data_oe, 1'b0);
   endtask : t_sync
   // Watchdog
   initial begin
      #(8 * 20000);
      err_total++;
      final_report();
   end
   // Main sequence
   initial begin
      rst = 1'b1;
      repeat (20) @(posedge clk);
      #1;
      rst = 1'b0;
      prog.step(1);
      chk8(data_out, 8'h00);
      chk1(data_oe, 1'b0);
      t_array();
      t_init();
      t_sync();
      final_report();
   end
endmodule : registered_prom_program_access_tb
`default_nettype wire
